// ===== src/rmpm_pkg.sv
// shared constants and types of the reset mode pin mux
package rmpm_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_SYSCTRL = 8'h00;
   localparam logic [7:0] OFS_FLAG_DIR = 8'h04;
   localparam logic [7:0] OFS_FLAG_OUT = 8'h08;
   localparam logic [7:0] OFS_FLAG_IN = 8'h0c;
   localparam logic [7:0] OFS_MODE = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   localparam logic [7:0] OFS_IRQ_PEND = 8'h18;
   localparam logic [7:0] OFS_COMB_SEL = 8'h1c;
   // field positions
   localparam int SC_PORT1_ALT = 0;
   localparam int SC_SENSE_LSB = 1;
   localparam int FO_FIXED_LSB = 8;
   localparam int FO_ALT = 11;
   localparam int FI_ALT = 8;
   localparam int MODE_HOST = 2;
   localparam int MODE_RUN = 4;
   localparam int IRQ_N = 6;
   localparam int IRQ_EDGE = 0;
   localparam int IRQ_LVL_A = 1;
   localparam int IRQ_LVL_B = 2;
   localparam int IRQ_CFG = 3;
   localparam int IRQ_ALT_A = 4;
   localparam int IRQ_ALT_B = 5;
   localparam int BYTE_PAGE_LSB = 16;
   // fixed edge sensitivity, configurable lines follow the sense bits
   localparam logic [5:0] IRQ_FIXED_EDGE = 6'h01;
   // reset values
   localparam logic [3:0] SYSCTRL_RST = 4'h0;
   localparam logic [7:0] FLAG_DIR_RST = 8'h00;
   localparam logic [11:0] FLAG_OUT_RST = 12'h000;
   localparam logic [5:0] IRQ_MASK_RST = 6'h00;
   localparam logic [3:0] COMB_SEL_RST = 4'h0;
   // address and data lanes that host mode keeps, byte page lanes of full mode
   localparam logic [13:0] HOST_ADDR_OE = 14'h0001;
   localparam logic [23:0] HOST_DATA_OE = 24'hffff00;
   localparam logic [23:0] BYTE_PAGE_OE = 24'hff0000;

   typedef enum logic [1:0] {
      RMPM_SP_DATA = 2'h0,
      RMPM_SP_PROG = 2'h1,
      RMPM_SP_IO = 2'h2,
      RMPM_SP_BYTE = 2'h3
   } rmpm_space_t;

   typedef enum logic [1:0] {
      RMPM_BUS_OWN = 2'b00,
      RMPM_BUS_GRANT = 2'b01,
      RMPM_BUS_HUNG = 2'b11
   } rmpm_bus_t;

   typedef struct packed {
      logic rd;
      logic wr;
      rmpm_space_t space;
      logic [13:0] addr;
      logic [7:0] byte_page;
      logic [23:0] wdata;
   } rmpm_mem_req_t;

   typedef struct packed {
      logic [3:0] sel_n;
      logic comb_sel_n;
      logic rd_n;
      logic wr_n;
      logic ctl_oe;
      logic [13:0] addr;
      logic [13:0] addr_oe;
      logic [23:0] data;
      logic [23:0] data_oe;
   } rmpm_mem_pins_t;
endpackage

// ===== src/rmpm_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module rmpm_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] q;
   } rmpm_sync_t;

   rmpm_sync_t s, next_s;

   always_comb begin
      next_s.meta = d;
      next_s.q = s.meta;
   end

   // no reset on purpose: mode straps must be visible right at release
   always_ff @(posedge clk) begin
      s <= next_s;
   end

   assign q = s.q;
endmodule // rmpm_sync
`default_nettype wire

// ===== src/rmpm_space_dec.sv
// external memory space selects, strobes and bus lanes
`timescale 1ns/100ps
`default_nettype none
module rmpm_space_dec
   import rmpm_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire rmpm_mem_req_t req,
   input wire logic [3:0] comb_sel,
   input wire logic host_mode,
   input wire logic granted,
   output rmpm_mem_pins_t pins
);
   rmpm_mem_pins_t s, next_s;
   logic act;

   always_comb begin
      act = (req.rd | req.wr) & ~granted;
      next_s = s;
      next_s.sel_n = 4'hf;
      next_s.sel_n[req.space] = ~act;
      next_s.comb_sel_n = ~(act & comb_sel[req.space]);
      next_s.rd_n = ~(act & req.rd);
      next_s.wr_n = ~(act & req.wr & ~req.rd);
      // a granted bus floats every pin for the other master
      next_s.ctl_oe = ~granted;
      next_s.addr = req.addr;
      next_s.addr_oe = granted ? '0 : (host_mode ? HOST_ADDR_OE : '1);
      next_s.data = req.wdata;
      next_s.data_oe = (act & req.wr) ? (host_mode ? HOST_DATA_OE : '1) : '0;
      if (act && !host_mode && req.space == RMPM_SP_BYTE) begin
         next_s.data[BYTE_PAGE_LSB +: 8] = req.byte_page;
         next_s.data_oe = next_s.data_oe | BYTE_PAGE_OE;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s <= '{sel_n: 4'hf, comb_sel_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign pins = s;
endmodule // rmpm_space_dec
`default_nettype wire

// ===== src/rmpm_top.sv
// reset mode latch and pin function multiplexer
// Notes on behaviour
// - bus pin roles fixed at reset only
// - serial port b roles change any time
// - interrupt and flag work together
// - mode pins sampled in reset, then flags
// - mode pin level at reset sets mode
// - mode pin low: full memory mode
// - host mode: host port, little addressing
// - mode pin high: host mode pins
// - full mode drives 14-bit address bus
// - 24-bit data, top byte carries page
// - one edge, two level, three configurable
// - enabled irq fires whoever drives pin
// - control bit moves port b to irq/flags
// - alternate frame syncs are low irqs
// - three fixed output flags, software written
// - bus request, grant and hung grant
// - per-space selects plus combined select
// - low read and write strobes
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module rmpm_top
   import rmpm_pkg::*;
(
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic ARST_N,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // general-purpose flag pins, low four are mode straps
   input wire logic [7:0] GP_FLAG_I,
   output logic [7:0] GP_FLAG_O,
   output logic [7:0] GP_FLAG_OE,
   output logic [2:0] FIXED_OUTPUT_FLAGS,
   // serial port b pins
   input wire logic PORT1_RX_FRAME_SYNC_I,
   output logic PORT1_RX_FRAME_SYNC_O,
   output logic PORT1_RX_FRAME_SYNC_OE,
   input wire logic PORT1_TX_FRAME_SYNC_I,
   output logic PORT1_TX_FRAME_SYNC_O,
   output logic PORT1_TX_FRAME_SYNC_OE,
   input wire logic PORT1_RX_LINE_I,
   output logic PORT1_TX_LINE_O,
   output logic PORT1_TX_LINE_OE,
   // serial port b core side
   input wire logic SPB_RFS_O,
   input wire logic SPB_RFS_OE,
   input wire logic SPB_TFS_O,
   input wire logic SPB_TFS_OE,
   input wire logic SPB_TX_O,
   input wire logic SPB_TX_OE,
   output logic SPB_RFS_I,
   output logic SPB_TFS_I,
   output logic SPB_RX_I,
   // interrupt requests to the sequencer
   output logic [5:0] IRQ_REQ,
   // mode outputs
   output logic HOST_DMA_EN,
   output logic BYTE_DMA_EN,
   // bus arbitration
   input wire logic BUS_REQUEST_N,
   output logic BUS_GRANT_N,
   output logic BUS_GRANT_HUNG_N,
   // external memory
   input wire rmpm_mem_req_t CORE_REQ,
   output logic CORE_STALL,
   output logic [23:0] CORE_RDATA,
   input wire logic [23:0] EXT_DATA_I,
   output rmpm_mem_pins_t MEM_PINS
);
   typedef struct packed {
      logic run;
      logic [3:0] mode;
      logic ack;
      logic slverr;
      logic [31:0] rdata;
      logic [3:0] sysctrl;
      logic [7:0] dir;
      logic [11:0] fout;
      logic [5:0] mask;
      logic [5:0] pend;
      logic [5:0] prev;
      logic [5:0] irq;
      logic [3:0] comb_sel;
      rmpm_bus_t bus;
      logic [5:0] p1;
   } rmpm_state_t;

   rmpm_state_t s, next_s;
   logic [35:0] sync_q;
   logic [7:0] flag_s;
   logic rfs_s, tfs_s, rx_s, breq_n_s;
   logic alt, host, breq, busy, access, wr_ack, clr_hit;
   logic [5:0] lvl, fall, is_edge, clr;

   rmpm_sync #(.W(36)) u_sync (
      .clk(CLK_SYS),
      .d({EXT_DATA_I, BUS_REQUEST_N, PORT1_RX_LINE_I, PORT1_TX_FRAME_SYNC_I,
          PORT1_RX_FRAME_SYNC_I, GP_FLAG_I}),
      .q(sync_q)
   );

   assign flag_s = sync_q[7:0];
   assign rfs_s = sync_q[8];
   assign tfs_s = sync_q[9];
   assign rx_s = sync_q[10];
   assign breq_n_s = sync_q[11];

   always_comb begin
      alt = s.sysctrl[SC_PORT1_ALT];
      host = s.mode[MODE_HOST];
      breq = ~breq_n_s;
      busy = CORE_REQ.rd | CORE_REQ.wr;
      access = PSEL & PENABLE;
      wr_ack = access & s.ack & PWRITE;
      // pin level counts, so a self-driven flag also interrupts
      lvl[IRQ_EDGE] = ~flag_s[4];
      lvl[IRQ_LVL_A] = ~flag_s[5];
      lvl[IRQ_LVL_B] = ~flag_s[6];
      lvl[IRQ_CFG] = ~flag_s[7];
      lvl[IRQ_ALT_A] = alt & ~rfs_s;
      lvl[IRQ_ALT_B] = alt & ~tfs_s;
      is_edge = IRQ_FIXED_EDGE | {s.sysctrl[SC_SENSE_LSB +: 3], 3'b000};
      fall = lvl & ~s.prev;
      clr_hit = wr_ack && PADDR == OFS_IRQ_PEND;
      clr = clr_hit ? PWDATA[IRQ_N-1:0] : '0;
   end

   always_comb begin
      next_s = s;
      // straps caught once, at the first edge after release
      if (!s.run) begin
         next_s.run = 1'b1;
         next_s.mode = flag_s[3:0];
      end
      // register bus, one wait state
      next_s.ack = access & ~s.ack;
      if (access && !s.ack) begin
         next_s.slverr = 1'b0;
         next_s.rdata = '0;
         case (PADDR)
            OFS_SYSCTRL: next_s.rdata[3:0] = s.sysctrl;
            OFS_FLAG_DIR: next_s.rdata[7:0] = s.dir;
            OFS_FLAG_OUT: next_s.rdata[11:0] = s.fout;
            OFS_FLAG_IN: next_s.rdata[8:0] = {alt & rx_s, flag_s};
            OFS_MODE: next_s.rdata[MODE_RUN:0] = {s.run, s.mode};
            OFS_IRQ_MASK: next_s.rdata[IRQ_N-1:0] = s.mask;
            OFS_IRQ_PEND: next_s.rdata[IRQ_N-1:0] = s.pend;
            OFS_COMB_SEL: next_s.rdata[3:0] = s.comb_sel;
            default: next_s.slverr = 1'b1;
         endcase
      end
      if (wr_ack) begin
         case (PADDR)
            OFS_SYSCTRL: next_s.sysctrl = PWDATA[3:0];
            OFS_FLAG_DIR: next_s.dir = PWDATA[7:0];
            OFS_FLAG_OUT: next_s.fout = PWDATA[11:0];
            OFS_IRQ_MASK: next_s.mask = PWDATA[IRQ_N-1:0];
            OFS_COMB_SEL: next_s.comb_sel = PWDATA[3:0];
            default: next_s.fout = s.fout;
         endcase
      end
      // a new edge beats a clear in the same cycle
      next_s.prev = lvl;
      next_s.pend = (s.pend & ~clr) | (fall & is_edge);
      next_s.irq = s.mask & ((is_edge & s.pend) | (~is_edge & lvl));
      // port b pins: alternate role floats frame syncs, drives flag out
      next_s.p1[0] = SPB_RFS_O;
      next_s.p1[1] = SPB_RFS_OE & ~alt;
      next_s.p1[2] = SPB_TFS_O;
      next_s.p1[3] = SPB_TFS_OE & ~alt;
      next_s.p1[4] = alt ? s.fout[FO_ALT] : SPB_TX_O;
      next_s.p1[5] = alt | SPB_TX_OE;
      // bus arbitration
      case (s.bus)
         RMPM_BUS_OWN: begin
            if (breq && !busy) begin
               next_s.bus = RMPM_BUS_GRANT;
            end
         end
         RMPM_BUS_GRANT: begin
            if (!breq) begin
               next_s.bus = RMPM_BUS_OWN;
            end else if (busy) begin
               next_s.bus = RMPM_BUS_HUNG;
            end
         end
         RMPM_BUS_HUNG: begin
            if (!breq) begin
               next_s.bus = RMPM_BUS_OWN;
            end else if (!busy) begin
               next_s.bus = RMPM_BUS_GRANT;
            end
         end
         default: next_s.bus = RMPM_BUS_OWN;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         s <= '{sysctrl: SYSCTRL_RST, dir: FLAG_DIR_RST, fout: FLAG_OUT_RST,
                mask: IRQ_MASK_RST, comb_sel: COMB_SEL_RST, bus: RMPM_BUS_OWN,
                default: '0};
      end else begin
         s <= next_s;
      end
   end

   // mode only changes through a new reset
   rmpm_space_dec u_dec (
      .clk(CLK_SYS),
      .arst_n(ARST_N),
      .req(CORE_REQ),
      .comb_sel(s.comb_sel),
      .host_mode(host),
      .granted(s.bus != RMPM_BUS_OWN),
      .pins(MEM_PINS)
   );

   assign PRDATA = s.rdata;
   assign PREADY = s.ack;
   assign PSLVERR = s.ack & s.slverr;
   assign GP_FLAG_O = s.fout[7:0];
   assign GP_FLAG_OE = s.run ? s.dir : '0;
   assign FIXED_OUTPUT_FLAGS = s.fout[FO_FIXED_LSB +: 3];
   assign PORT1_RX_FRAME_SYNC_O = s.p1[0];
   assign PORT1_RX_FRAME_SYNC_OE = s.p1[1];
   assign PORT1_TX_FRAME_SYNC_O = s.p1[2];
   assign PORT1_TX_FRAME_SYNC_OE = s.p1[3];
   assign PORT1_TX_LINE_O = s.p1[4];
   assign PORT1_TX_LINE_OE = s.p1[5];
   // port b core sees idle levels while its pins are borrowed
   assign SPB_RFS_I = alt | rfs_s;
   assign SPB_TFS_I = alt | tfs_s;
   assign SPB_RX_I = alt | rx_s;
   assign IRQ_REQ = s.irq;
   assign HOST_DMA_EN = s.run & host;
   assign BYTE_DMA_EN = s.run & ~host;
   assign BUS_GRANT_N = s.bus == RMPM_BUS_OWN;
   assign BUS_GRANT_HUNG_N = s.bus != RMPM_BUS_HUNG;
   // limitation: the core must hold its request while stalled
   assign CORE_STALL = busy & (s.bus != RMPM_BUS_OWN);
   assign CORE_RDATA = sync_q[35:12];

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!ARST_N);

   sequence seq_req_idle;
      !BUS_REQUEST_N && !busy;
   endsequence

   sequence seq_edge_fall;
      fall[IRQ_EDGE] ##0 is_edge[IRQ_EDGE];
   endsequence

   a_mode_hold: assert property (s.run |=> $stable(s.mode))
      else $error("mode changed without reset");
   a_mode_capture: assert property (!s.run |=> s.mode == $past(flag_s[3:0]))
      else $error("mode not captured at release");
   a_mode_dma: assert property (s.run |-> HOST_DMA_EN == s.mode[MODE_HOST]
                                && BYTE_DMA_EN == !s.mode[MODE_HOST])
      else $error("dma enables disagree with mode");
   a_host_addr: assert property (s.run && host |=> MEM_PINS.addr_oe[13:1] == '0)
      else $error("host mode drives upper address");
   a_flag_oe_reset: assert property (!s.run |-> GP_FLAG_OE == '0)
      else $error("flag pins driven before mode capture");
   a_alt_pins: assert property (alt |=> !PORT1_RX_FRAME_SYNC_OE
                                && !PORT1_TX_FRAME_SYNC_OE && PORT1_TX_LINE_OE
                                && PORT1_TX_LINE_O == $past(s.fout[FO_ALT]))
      else $error("alternate port pins wrong");
   a_sysctrl_write: assert property (wr_ack && PADDR == OFS_SYSCTRL
                                     |=> s.sysctrl == $past(PWDATA[3:0]))
      else $error("control write lost");
   a_level_irq: assert property (s.mask[IRQ_LVL_A] && lvl[IRQ_LVL_A]
                                 |=> IRQ_REQ[IRQ_LVL_A])
      else $error("level request not raised");
   a_edge_pend: assert property (seq_edge_fall |=> (s.pend[IRQ_EDGE] and
                                 (s.mask[IRQ_EDGE] |=> IRQ_REQ[IRQ_EDGE])))
      else $error("edge request lost");
   a_set_wins: assert property (fall[IRQ_EDGE] && clr[IRQ_EDGE] |=> s.pend[IRQ_EDGE])
      else $error("clear beat new edge");
   a_bus_grant: assert property (seq_req_idle [*4] |=> !BUS_GRANT_N)
      else $error("bus not granted");
   a_bus_hung: assert property (s.bus == RMPM_BUS_GRANT && breq && busy
                                |=> !BUS_GRANT_HUNG_N && !BUS_GRANT_N)
      else $error("hung grant not shown");
   a_read_strobe: assert property (CORE_REQ.rd && s.bus == RMPM_BUS_OWN
                                   |=> !MEM_PINS.rd_n && MEM_PINS.wr_n)
      else $error("read strobe missing");
   a_byte_page: assert property (CORE_REQ.rd && !host && s.bus == RMPM_BUS_OWN
                                 && CORE_REQ.space == RMPM_SP_BYTE
                                 |=> MEM_PINS.data[23:16] == $past(CORE_REQ.byte_page)
                                 && !MEM_PINS.sel_n[RMPM_SP_BYTE])
      else $error("byte page not on data bus");
endmodule // rmpm_top
`default_nettype wire

// ===== tb/rmpm_mem_model.sv
// external memory model on the far side of the memory pins
`timescale 1ns/100ps
`default_nettype none
module rmpm_mem_model
   import rmpm_pkg::*;
(
   // clock
   input wire logic clk,
   // pins from the device
   input wire rmpm_mem_pins_t pins,
   // data lines back to the device
   output logic [23:0] rdata
);
   logic [23:0] mem [16];
   logic [23:0] last;
   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = 24'h000000;
      end
      last = 24'h000000;
   end
   // store only while a select and the low write strobe are both active
   always @(posedge clk) begin
      if (!pins.wr_n && (pins.sel_n != 4'hf)) begin
         mem[pins.addr[3:0]] <= pins.data;
      end
      if (!pins.rd_n) begin
         last <= rdata;
      end
   end
   // released lines do not keep the last value
   always_comb begin
      rdata = (!pins.rd_n) ? mem[pins.addr[3:0]] : ~last;
   end
endmodule // rmpm_mem_model
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the reset mode pin mux
`timescale 1ns/100ps
`default_nettype none
module tb
   import rmpm_pkg::*;
;
   logic clk, arst_n, psel, penable, pwrite, pready, pslverr, host_en, byte_en, err;
   logic [7:0] paddr, gp_ext, gp_o, gp_oe, fl;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] fixed;
   logic rfs_ext, tfs_ext, rx_ext, rfs_o, rfs_oe, tfs_o, tfs_oe, tx_o, tx_oe;
   logic s_rfs_o, s_rfs_oe, s_tfs_o, s_tfs_oe, s_tx_o, s_tx_oe, s_rfs_i, s_tfs_i, s_rx_i;
   logic [5:0] irq;
   logic br_n, bg_n, bgh_n, stall;
   logic [13:0] a;
   logic [23:0] d, core_rdata, ext_data;
   rmpm_mem_req_t req;
   rmpm_mem_pins_t pins;
   int fails, check_count;
   // pin levels: device driver wins where enabled
   wire logic [7:0] gp_pin = (gp_oe & gp_o) | (~gp_oe & gp_ext);
   wire logic rfs_pin = rfs_oe ? rfs_o : rfs_ext;
   wire logic tfs_pin = tfs_oe ? tfs_o : tfs_ext;
   rmpm_top DUT (.CLK_SYS(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .GP_FLAG_I(gp_pin), .GP_FLAG_O(gp_o), .GP_FLAG_OE(gp_oe),
      .FIXED_OUTPUT_FLAGS(fixed), .PORT1_RX_FRAME_SYNC_I(rfs_pin),
      .PORT1_RX_FRAME_SYNC_O(rfs_o), .PORT1_RX_FRAME_SYNC_OE(rfs_oe),
      .PORT1_TX_FRAME_SYNC_I(tfs_pin), .PORT1_TX_FRAME_SYNC_O(tfs_o),
      .PORT1_TX_FRAME_SYNC_OE(tfs_oe), .PORT1_RX_LINE_I(rx_ext), .PORT1_TX_LINE_O(tx_o),
      .PORT1_TX_LINE_OE(tx_oe), .SPB_RFS_O(s_rfs_o), .SPB_RFS_OE(s_rfs_oe),
      .SPB_TFS_O(s_tfs_o), .SPB_TFS_OE(s_tfs_oe), .SPB_TX_O(s_tx_o), .SPB_TX_OE(s_tx_oe),
      .SPB_RFS_I(s_rfs_i), .SPB_TFS_I(s_tfs_i), .SPB_RX_I(s_rx_i), .IRQ_REQ(irq),
      .HOST_DMA_EN(host_en), .BYTE_DMA_EN(byte_en), .BUS_REQUEST_N(br_n),
      .BUS_GRANT_N(bg_n), .BUS_GRANT_HUNG_N(bgh_n), .CORE_REQ(req), .CORE_STALL(stall),
      .CORE_RDATA(core_rdata), .EXT_DATA_I(ext_data), .MEM_PINS(pins));
   rmpm_mem_model mem_model (.clk(clk), .pins(pins), .rdata(ext_data));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function automatic logic [31:0] mode_exp(input logic [3:0] s);
      return {27'h0, 1'b1, s};
   endfunction
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // no own limit: only the watchdog ends a hung access
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // straps stay steady for the whole reset
   task do_reset(input logic [3:0] strap);
      @(posedge clk);
      arst_n <= 1'b0;
      gp_ext <= {4'hf, strap};
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      cyc(2);
   endtask
   task end_sim();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      end_sim();
   end
   initial begin
      arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
      pwdata = 32'h0; gp_ext = 8'hff; rfs_ext = 1'b1; tfs_ext = 1'b1; rx_ext = 1'b1;
      s_rfs_o = 1'b1; s_rfs_oe = 1'b1; s_tfs_o = 1'b1; s_tfs_oe = 1'b0; s_tx_o = 1'b1;
      s_tx_oe = 1'b1; br_n = 1'b1; req = '0; fails = 0; check_count = 0;
      void'($urandom(26541));
      do_reset(4'h4);
      apb(1'b0, OFS_MODE, 32'h0);
      chk("mode host", rd, mode_exp(4'h4));
      chk("host dma", 32'({host_en, byte_en}), 32'h2);
      @(posedge clk) gp_ext <= 8'hf3;
      cyc(4);
      apb(1'b0, OFS_MODE, 32'h0);
      chk("mode held", rd, mode_exp(4'h4));
      apb(1'b0, OFS_FLAG_IN, 32'h0);
      chk("straps as flags", rd & 32'hff, 32'hf3);
      do_reset(4'h0);
      chk("full mode", 32'({host_en, byte_en}), 32'h1);
      apb(1'b1, OFS_MODE, 32'hf);
      apb(1'b0, OFS_MODE, 32'h0);
      chk("mode read only", rd, mode_exp(4'h0));
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped err", 32'(err), 32'h1);
      chk("unmapped data", rd, 32'h0);
      $display("test mode finished");
      for (int i = 0; i < 3; i++) begin
         fl = 8'($urandom_range(7));
         apb(1'b1, OFS_FLAG_OUT, {21'h0, fl[2:0], 8'h00});
         cyc(2);
         chk("fixed flags", 32'(fixed), 32'(fl));
      end
      // flag 6 driven low by the device, flag 5 pulled low outside
      @(posedge clk) gp_ext <= 8'hdf;
      apb(1'b1, OFS_FLAG_DIR, 32'h40);
      apb(1'b1, OFS_FLAG_OUT, 32'h0);
      apb(1'b1, OFS_IRQ_MASK, 32'h02);
      cyc(5);
      chk("mask one", 32'(irq[2:1]), 32'h1);
      apb(1'b1, OFS_IRQ_MASK, 32'h06);
      cyc(5);
      chk("mask both", 32'(irq[2:1]), 32'h3);
      apb(1'b0, OFS_FLAG_IN, 32'h0);
      chk("flags with irq", rd & 32'h60, 32'h0);
      chk("flag drive", 32'({gp_oe, gp_o}), 32'h4000);
      // flags 7 and 4 fall: fixed edge line and line 3 set to edge sense
      apb(1'b1, OFS_IRQ_MASK, 32'h09);
      apb(1'b1, OFS_SYSCTRL, 32'h2);
      @(posedge clk) gp_ext <= 8'h4f;
      cyc(5);
      chk("edge irqs", 32'({irq[3], irq[0]}), 32'h3);
      apb(1'b0, OFS_IRQ_PEND, 32'h0);
      chk("edge pending", rd, 32'h09);
      apb(1'b1, OFS_IRQ_PEND, 32'h09);
      cyc(3);
      chk("edge cleared", 32'({irq[3], irq[0]}), 32'h0);
      $display("test flags finished");
      chk("port b normal", 32'({rfs_oe, tx_o, tx_oe}), 32'h7);
      chk("port b syncs", 32'({rfs_o, tfs_o, tfs_oe, s_tfs_i, s_rx_i}), 32'h1b);
      @(posedge clk) rfs_ext <= 1'b0;
      apb(1'b1, OFS_SYSCTRL, 32'h1);
      apb(1'b1, OFS_IRQ_MASK, 32'h10);
      cyc(5);
      chk("port b alt", 32'({rfs_oe, tx_oe, tx_o, irq[4], s_rfs_i}), 32'h0b);
      apb(1'b0, OFS_FLAG_IN, 32'h0);
      chk("alt flag in", 32'(rd[8]), 32'h1);
      apb(1'b1, OFS_SYSCTRL, 32'h0);
      cyc(5);
      chk("port b back", 32'({rfs_oe, irq[4]}), 32'h2);
      $display("test port finished");
      @(posedge clk) br_n <= 1'b0;
      cyc(6);
      chk("grant", 32'({bg_n, bgh_n}), 32'h1);
      @(posedge clk) req <= {1'b1, 1'b0, RMPM_SP_DATA, 14'h0, 8'h00, 24'h0};
      cyc(3);
      chk("hung", 32'({bg_n, bgh_n, stall}), 32'h1);
      chk("bus floated", 32'({pins.ctl_oe, pins.addr_oe}), 32'h0);
      @(posedge clk) begin
         req <= '0;
         br_n <= 1'b1;
      end
      cyc(6);
      chk("released", 32'({bg_n, bgh_n}), 32'h3);
      $display("test bus finished");
      apb(1'b1, OFS_COMB_SEL, 32'h1);
      for (int i = 0; i < 4; i++) begin
         a = 14'($urandom);
         d = 24'($urandom);
         fl = 8'($urandom);
         @(posedge clk) req <= {1'b0, 1'b1, RMPM_SP_DATA, a, 8'h00, d};
         cyc(2);
         chk("write strobes", 32'({pins.sel_n, pins.comb_sel_n, pins.rd_n, pins.wr_n}), 32'h72);
         chk("address", 32'(pins.addr), 32'(a));
         chk("write data", 32'(pins.data), 32'(d));
         chk("addr lanes", 32'({pins.ctl_oe, pins.addr_oe}), 32'h7fff);
         chk("data lanes", 32'(pins.data_oe), 32'hffffff);
         @(posedge clk) req <= {1'b1, 1'b0, RMPM_SP_DATA, a, 8'h00, 24'h0};
         cyc(5);
         chk("read strobe", 32'({pins.rd_n, pins.wr_n}), 32'h1);
         chk("read data", 32'(core_rdata), 32'(d));
         @(posedge clk) req <= {1'b0, 1'b1, RMPM_SP_BYTE, a, fl, d};
         cyc(2);
         chk("byte sel", 32'({pins.sel_n, pins.comb_sel_n}), 32'h0f);
         chk("byte page", 32'(pins.data[23:16]), 32'(fl));
         @(posedge clk) req <= '0;
         cyc(1);
      end
      $display("test memory finished");
      end_sim();
   end
endmodule // tb
`default_nettype wire
